/* File: src/buck_switch_control_logic.sv */
// Switch control sequencer for a synchronous step-down converter.
//
// Behaviour
// [R1] High-side on at each period start.
// [R2] Loop trip: high off, low on.
// [R3] Low-side stays on to period end.
// [R4] Sixteen zero-cross periods in row enter skip.
// [R5] Period without zero-cross clears counter.
// [R6] Skip pulse: on at clock, off near 20%.
// [R7] Skip upper margin: high off, idle.
// [R8] Skip idle restarts at nominal output.
// [R9] Below lower margin returns to pulse-width.
// [R10] Enable wakes reference, then soft-start.
// [R11] Disable: switches off, discharge on.
// [R12] Overcurrent turns high-side off immediately.
// [R13] Short-circuit selects much lower frequency.
// [R14] Undervoltage holds converter disabled.
// [R15] Dropout holds high-side fully on; code ignores dropout in skip mode.
// [R16] Over-temperature shuts down; restart via soft-start.
// [R17] Soft-start ramps both loop references.
// [R18] Never both switches on; non-overlap gap.
// [R19] Synchronise inputs except immediate turn-off.
`timescale 1ns/1ps
module buck_switch_control_logic #(
   parameter int SOFT_START_CYCLES = buck_ctrl_pkg::SOFT_START_CYC
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic enable_in,
   input wire logic supply_low_lockout_in,
   input wire logic over_temp_in,
   input wire logic loop_trip_in,
   input wire logic overcurrent_trip_in,
   input wire logic skip_trip_in,
   input wire logic zero_cross_in,
   input wire logic output_short_detect_in,
   input wire logic out_above_upper_in,
   input wire logic out_below_nominal_in,
   input wire logic out_below_lower_in,
   input wire logic dropout_in,
   output logic high_gate_out,
   output logic low_gate_out,
   output logic discharge_out,
   output logic reference_wake_out,
   output logic soft_start_active_out,
   output logic [15:0] soft_start_ramp_out,
   output logic skip_mode_out,
   output logic period_start_out
);
   localparam int NS = 11;
   localparam logic [15:0] SS_LAST =
      16'(SOFT_START_CYCLES - 1);

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [NS-1:0] raw;
   logic [NS-1:0] sync1_ff;
   logic [NS-1:0] sync2_ff;

   assign raw = {enable_in, supply_low_lockout_in, over_temp_in,
      loop_trip_in, skip_trip_in, zero_cross_in, output_short_detect_in,
      out_above_upper_in, out_below_nominal_in, out_below_lower_in,
      dropout_in};

   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         always_ff @(posedge clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
            end else begin
               sync1_ff[gi] <= raw[gi];
               sync2_ff[gi] <= sync1_ff[gi]; // [R19]
            end
         end
      end
   endgenerate

   logic en_s, supply_low_lockout_s, hot_s, trip_s, skip_s, zc_s, short_s;
   logic above_s, nom_s, lower_s, drop_s;
   assign {en_s, supply_low_lockout_s, hot_s, trip_s, skip_s, zc_s, short_s,
      above_s, nom_s, lower_s, drop_s} = sync2_ff;

   // ==========================================================
   // Enable, lockout and thermal sequencing
   // ==========================================================
   buck_ctrl_pkg::seq_state_t seq_ff;
   buck_ctrl_pkg::seq_state_t nxt_seq;
   logic [7:0] wake_cnt_ff;
   logic [15:0] ss_cnt_ff;
   logic run_ok;

   assign run_ok = en_s && !supply_low_lockout_s; // [R14]

   always_comb begin
      nxt_seq = seq_ff;
      case (seq_ff)
         buck_ctrl_pkg::ST_OFF: begin
            if (run_ok && !hot_s) begin
               nxt_seq = buck_ctrl_pkg::ST_WAKE; // [R10]
            end
         end
         buck_ctrl_pkg::ST_WAKE: begin
            if (wake_cnt_ff == buck_ctrl_pkg::REF_WAKE_CYCLES) begin
               nxt_seq = buck_ctrl_pkg::ST_SOFT; // [R10]
            end
         end
         buck_ctrl_pkg::ST_SOFT: begin
            if (ss_cnt_ff == SS_LAST[15:0]) begin
               nxt_seq = buck_ctrl_pkg::ST_RUN;
            end
         end
         buck_ctrl_pkg::ST_RUN: nxt_seq = seq_ff;
         buck_ctrl_pkg::ST_HOT: begin
            if (!hot_s) begin
               nxt_seq = buck_ctrl_pkg::ST_WAKE; // [R16]
            end
         end
         default: nxt_seq = buck_ctrl_pkg::ST_OFF;
      endcase
      if (!run_ok) begin
         nxt_seq = buck_ctrl_pkg::ST_OFF; // [R11] [R14]
      end else if (hot_s) begin
         nxt_seq = buck_ctrl_pkg::ST_HOT; // [R16]
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         seq_ff <= buck_ctrl_pkg::ST_OFF;
      end else begin
         seq_ff <= nxt_seq;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wake_cnt_ff <= 8'h00;
      end else if (seq_ff == buck_ctrl_pkg::ST_WAKE) begin
         wake_cnt_ff <= wake_cnt_ff + 8'h01;
      end else begin
         wake_cnt_ff <= 8'h00;
      end
   end

   // Soft-start count doubles as the ramp reference for both loops.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ss_cnt_ff <= 16'h0000;
      end else if (seq_ff == buck_ctrl_pkg::ST_SOFT) begin
         ss_cnt_ff <= ss_cnt_ff + 16'h0001; // [R17]
      end else if (seq_ff != buck_ctrl_pkg::ST_RUN) begin
         ss_cnt_ff <= 16'h0000; // [R16]
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         soft_start_ramp_out <= 16'h0000;
      end else if (seq_ff == buck_ctrl_pkg::ST_RUN) begin
         soft_start_ramp_out <= 16'hffff;
      end else begin
         soft_start_ramp_out <= ss_cnt_ff; // [R17]
      end
   end

   logic active;
   assign active = (seq_ff == buck_ctrl_pkg::ST_SOFT) ||
      (seq_ff == buck_ctrl_pkg::ST_RUN);

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         discharge_out <= 1'b1;
         reference_wake_out <= 1'b0;
         soft_start_active_out <= 1'b0;
      end else begin
         discharge_out <= !en_s; // [R11]
         reference_wake_out <= (nxt_seq != buck_ctrl_pkg::ST_OFF) &&
            (nxt_seq != buck_ctrl_pkg::ST_HOT); // [R10]
         soft_start_active_out <= nxt_seq == buck_ctrl_pkg::ST_SOFT;
      end
   end

   // ==========================================================
   // Oscillator with short-circuit foldback
   // ==========================================================
   logic [7:0] osc_cnt_ff;
   logic [7:0] period_len;
   logic tick;

   assign period_len = short_s ? buck_ctrl_pkg::PERIOD_FOLDBACK :
      buck_ctrl_pkg::PERIOD_NORMAL; // [R13]
   assign tick = active && (osc_cnt_ff == 8'h00);

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         osc_cnt_ff <= 8'h00;
      end else if (!active || osc_cnt_ff >= period_len - 8'h01) begin
         osc_cnt_ff <= 8'h00; // [R13]
      end else begin
         osc_cnt_ff <= osc_cnt_ff + 8'h01;
      end
   end

   assign period_start_out = tick;

   // ==========================================================
   // Zero-cross counter and skip mode
   // ==========================================================
   logic [4:0] zc_cnt_ff;
   logic zc_seen_ff;
   logic skip_ff;
   logic skip_idle_ff;

   // A crossing anywhere in the period is remembered until the period ends.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         zc_seen_ff <= 1'b0;
      end else if (tick) begin
         zc_seen_ff <= zc_s;
      end else if (zc_s) begin
         zc_seen_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         zc_cnt_ff <= 5'h00;
      end else if (!active || skip_ff) begin
         zc_cnt_ff <= 5'h00;
      end else if (tick) begin
         if (zc_seen_ff) begin
            zc_cnt_ff <= zc_cnt_ff + 5'h01; // [R4]
         end else begin
            zc_cnt_ff <= 5'h00; // [R5]
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         skip_ff <= 1'b0;
      end else if (!active || lower_s) begin
         skip_ff <= 1'b0; // [R9]
      end else if (zc_cnt_ff == buck_ctrl_pkg::ZC_RUN_LEN) begin
         skip_ff <= 1'b1; // [R4]
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         skip_idle_ff <= 1'b0;
      end else if (!skip_ff) begin
         skip_idle_ff <= 1'b0;
      end else if (above_s) begin
         skip_idle_ff <= 1'b1; // [R7]
      end else if (nom_s) begin
         skip_idle_ff <= 1'b0; // [R8]
      end
   end

   assign skip_mode_out = skip_ff;

   // ==========================================================
   // Switch phase control
   // ==========================================================
   buck_ctrl_pkg::phase_t ph_ff;
   buck_ctrl_pkg::phase_t nxt_ph;

   always_comb begin
      nxt_ph = ph_ff;
      case (ph_ff)
         buck_ctrl_pkg::PH_IDLE: begin
            if (tick && !(skip_ff && (skip_idle_ff || above_s))) begin
               nxt_ph = buck_ctrl_pkg::PH_HIGH; // [R1] [R6] [R8]
            end
         end
         buck_ctrl_pkg::PH_HIGH: begin
            if (drop_s && !skip_ff) begin
               nxt_ph = buck_ctrl_pkg::PH_HIGH; // [R15]
            end else if (skip_ff && (skip_s || above_s)) begin
               nxt_ph = buck_ctrl_pkg::PH_IDLE; // [R6] [R7]
            end else if (!skip_ff && trip_s) begin
               nxt_ph = buck_ctrl_pkg::PH_LOW; // [R2]
            end else if (tick && !skip_ff) begin
               nxt_ph = buck_ctrl_pkg::PH_HIGH;
            end
         end
         buck_ctrl_pkg::PH_LOW: begin
            if (tick) begin
               nxt_ph = buck_ctrl_pkg::PH_HIGH; // [R3]
            end
         end
         default: nxt_ph = buck_ctrl_pkg::PH_IDLE;
      endcase
      if (!active) begin
         nxt_ph = buck_ctrl_pkg::PH_IDLE; // [R11] [R14] [R16]
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ph_ff <= buck_ctrl_pkg::PH_IDLE;
      end else begin
         ph_ff <= nxt_ph;
      end
   end

   // Overcurrent is taken raw so the high-side drops in the same cycle.
   gate_nonoverlap u_gate (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .want_high_in(ph_ff == buck_ctrl_pkg::PH_HIGH),
      .want_low_in(ph_ff == buck_ctrl_pkg::PH_LOW),
      .kill_high_in(overcurrent_trip_in), // [R12]
      .high_gate_out(high_gate_out),
      .low_gate_out(low_gate_out)
   );
endmodule

/* File: src/buck_ctrl_pkg.sv */
// Constants and types shared by the buck switch control logic.
package buck_ctrl_pkg;
   // Zero-cross run length that enters skip mode.
   localparam logic [4:0] ZC_RUN_LEN = 5'h10;
   // Gate non-overlap interval, in clock cycles.
   localparam logic [1:0] DEAD_CYCLES = 2'h1;
   // Reference wake-up time, in clock cycles.
   localparam logic [7:0] REF_WAKE_CYCLES = 8'h20;
   // Soft-start duration (typical 1 ms) and its count at 40 MHz.
   localparam int SOFT_START_US = 1000;
   localparam int CLK_MHZ = 40;
   localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
   // Oscillator period in clock cycles, normal and short-circuit foldback.
   localparam logic [7:0] PERIOD_NORMAL = 8'h0a;
   localparam logic [7:0] PERIOD_FOLDBACK = 8'ha0;
   localparam int SS_W = 16;

   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_WAKE = 5'h02,
      ST_SOFT = 5'h04,
      ST_RUN = 5'h08,
      ST_HOT = 5'h10
   } seq_state_t;

   typedef enum logic [2:0] {
      PH_IDLE = 3'h1,
      PH_HIGH = 3'h2,
      PH_LOW = 3'h4
   } phase_t;
endpackage

/* File: src/gate_nonoverlap.sv */
// Non-overlap gate driver stage for the two power switches.
`timescale 1ns/1ps
module gate_nonoverlap (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic want_high_in,
   input wire logic want_low_in,
   input wire logic kill_high_in,
   output logic high_gate_out,
   output logic low_gate_out
);
   logic [1:0] dead_ff;
   logic high_ff;
   logic low_ff;

   // The wait counts from the cycle both gates are seen off.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dead_ff <= 2'h0;
      end else if (high_ff || low_ff) begin
         dead_ff <= buck_ctrl_pkg::DEAD_CYCLES;
      end else if (dead_ff != 2'h0) begin
         dead_ff <= dead_ff - 2'h1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         high_ff <= 1'b0;
         low_ff <= 1'b0;
      end else begin
         if (!want_high_in || kill_high_in) begin
            high_ff <= 1'b0;
         end else if (!low_ff && dead_ff == 2'h0) begin
            high_ff <= 1'b1; // [R18]
         end
         if (!want_low_in) begin
            low_ff <= 1'b0;
         end else if (!high_ff && !want_high_in && dead_ff == 2'h0) begin
            low_ff <= 1'b1; // [R18]
         end
      end
   end

   // Immediate turn-off path bypasses the flip-flop.
   assign high_gate_out = high_ff & ~kill_high_in; // [R12] [R19]
   assign low_gate_out = low_ff & ~high_gate_out; // [R18]
endmodule

/* File: tb/buck_switch_control_logic_chk.sv */
// Port checks for the buck switch control logic.
`timescale 1ns/1ps
module buck_ctrl_chk #(
   parameter int SOFT_START_CYCLES = 50
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic enable_in,
   input wire logic supply_low_lockout_in,
   input wire logic over_temp_in,
   input wire logic loop_trip_in,
   input wire logic overcurrent_trip_in,
   input wire logic dropout_in,
   input wire logic high_gate_out,
   input wire logic low_gate_out,
   input wire logic reference_wake_out,
   input wire logic soft_start_active_out,
   input wire logic [15:0] soft_start_ramp_out,
   input wire logic skip_mode_out,
   input wire logic period_start_out
);
   // ======================================
   // Checks
   localparam int SS_HI = SOFT_START_CYCLES + 2;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   property p_no_overlap;
      !(high_gate_out && low_gate_out);
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("gates overlap");
   property p_dead_time;
      $rose(high_gate_out) || $rose(low_gate_out) |->
         !$past(high_gate_out) && !$past(low_gate_out);
   endproperty
   a_dead_time: assert property (p_dead_time)
      else $error("no gap between gates");
   property p_oc_kill;
      overcurrent_trip_in |-> !high_gate_out;
   endproperty
   a_oc_kill: assert property (p_oc_kill)
      else $error("high gate on during overcurrent");
   // The gate follows the phase register, and the non-overlap gap when
   // the low side was on, so it rises two to four cycles after the start.
   // A recent overcurrent cut can leave a late loop trip pending, so the
   // check starts eight clean cycles after one.
   property p_pwm_on;
      (enable_in && !supply_low_lockout_in && !over_temp_in &&
         !overcurrent_trip_in)[*8] ##0 period_start_out &&
         soft_start_ramp_out == 16'hffff && !skip_mode_out |->
         ##[2:4] (high_gate_out || overcurrent_trip_in);
   endproperty
   a_pwm_on: assert property (p_pwm_on)
      else $error("high gate missed period start");
   property p_trip_off;
      (!dropout_in)[*3] ##0 $rose(loop_trip_in) && high_gate_out &&
         !skip_mode_out |-> ##4 !high_gate_out;
   endproperty
   a_trip_off: assert property (p_trip_off)
      else $error("high gate kept on after trip");
   property p_wake_first;
      $rose(soft_start_active_out) |-> $past(reference_wake_out);
   endproperty
   a_wake_first: assert property (p_wake_first)
      else $error("soft-start before reference");
   property p_hold_off;
      (supply_low_lockout_in || over_temp_in || !enable_in)[*6] |->
         !high_gate_out && !low_gate_out && !soft_start_active_out;
   endproperty
   a_hold_off: assert property (p_hold_off)
      else $error("switching while held off");
   property p_dropout;
      (dropout_in && enable_in && !over_temp_in && !supply_low_lockout_in)[*4]
         ##0 high_gate_out |=> high_gate_out || overcurrent_trip_in;
   endproperty
   a_dropout: assert property (p_dropout)
      else $error("high gate dropped in dropout");
   property p_ss_len;
      $rose(soft_start_active_out) |-> ##[1:SS_HI] !soft_start_active_out;
   endproperty
   a_ss_len: assert property (p_ss_len)
      else $error("soft-start too long");
endmodule

/* File: tb/buck_analog_model.sv */
// Behavioural comparator front end facing the switch control logic.
`timescale 1ns/1ps
module buck_analog_model (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic high_gate_in,
   input wire logic low_gate_in,
   input wire logic light_load_in,
   input wire logic slow_in,
   output logic loop_trip_out,
   output logic skip_trip_out,
   output logic zero_cross_out
);
   // ======================================
   // Inductor current model
   logic [1:0] on_cnt_ff;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         on_cnt_ff <= 2'h0;
      end else if (!high_gate_in) begin
         on_cnt_ff <= 2'h0;
      end else if (on_cnt_ff != 2'h3) begin
         on_cnt_ff <= on_cnt_ff + 2'h1;
      end
   end
   // A slow ramp reaches the peak two on-cycles later.
   assign loop_trip_out = high_gate_in && (!slow_in || on_cnt_ff[1]);
   assign skip_trip_out = high_gate_in;
   // Current falls through zero while the low side conducts at light load.
   assign zero_cross_out = light_load_in && low_gate_in;
endmodule

/* File: tb/buck_switch_control_logic_tb.sv */
// Self-checking bench for the buck switch control logic.
`timescale 1ns/1ps
module buck_switch_control_logic_tb;
   localparam int SOFT_START_CYCLES = 50;
   logic clk_in, reset_n_in, enable_in, supply_low_lockout_in, over_temp_in;
   logic overcurrent_trip_in, output_short_detect_in, out_above_upper_in;
   logic out_below_nominal_in, out_below_lower_in, dropout_in, light_load;
   logic slow, loop_trip_in, skip_trip_in, zero_cross_in, high_gate_out;
   logic low_gate_out, discharge_out, reference_wake_out;
   logic soft_start_active_out, skip_mode_out, period_start_out;
   logic [15:0] soft_start_ramp_out;
   int miscompares = 0;
   int cmp_count = 0;
   int n, k;
   buck_switch_control_logic #(.SOFT_START_CYCLES(SOFT_START_CYCLES)) dut (
      .clk_in, .reset_n_in, .enable_in, .supply_low_lockout_in,
      .over_temp_in, .loop_trip_in, .overcurrent_trip_in, .skip_trip_in,
      .zero_cross_in, .output_short_detect_in, .out_above_upper_in,
      .out_below_nominal_in, .out_below_lower_in, .dropout_in,
      .high_gate_out, .low_gate_out, .discharge_out, .reference_wake_out,
      .soft_start_active_out, .soft_start_ramp_out, .skip_mode_out,
      .period_start_out);
   buck_analog_model pm (.clk_in, .reset_n_in, .high_gate_in(high_gate_out),
      .low_gate_in(low_gate_out), .light_load_in(light_load),
      .slow_in(slow), .loop_trip_out(loop_trip_in),
      .skip_trip_out(skip_trip_in), .zero_cross_out(zero_cross_in));
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // ======================================
   // Helpers
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge clk_in);
   endtask
   // Wait targets: 0 period, 1 wake, 2 soft, 3 run, 4 skip, 5 high, 6 pwm.
   function automatic logic pick(input int s);
      case (s)
         0: pick = period_start_out;
         1: pick = reference_wake_out;
         2: pick = soft_start_active_out;
         3: pick = soft_start_ramp_out === 16'hffff;
         4: pick = skip_mode_out;
         5: pick = high_gate_out;
         default: pick = !skip_mode_out;
      endcase
   endfunction
   task automatic wait_for(input int s, input int lim);
      n = 0;
      while (pick(s) !== 1'b1) begin
         if (n == lim) begin
            miscompares++;
            $display("wrong value at %0t: wait %h, limit %h", $time, s, lim);
            conclude();
         end
         cyc(1);
         n++;
      end
   endtask
   task automatic plen();
      wait_for(0, 400);
      cyc(1);
      wait_for(0, 400);
   endtask
   task automatic off_for(input int c);
      k = 0;
      repeat (c) begin
         if (high_gate_out !== 1'b0 || low_gate_out !== 1'b0) k++;
         cyc(1);
      end
      chk(k[15:0], 16'h0);
   endtask
   task automatic run_up();
      wait_for(2, 80);
      wait_for(3, SOFT_START_CYCLES + 10);
   endtask
   // ======================================
   // Scenarios
   task automatic t_startup();
      enable_in = 1'b1;
      wait_for(1, 10);
      chk(soft_start_active_out, 16'h0);
      wait_for(2, 60);
      cyc(10);
      k = soft_start_ramp_out;
      cyc(10);
      chk(soft_start_ramp_out > k[15:0], 16'h1);
      wait_for(3, SOFT_START_CYCLES + 10);
      chk(soft_start_active_out, 16'h0);
   endtask
   task automatic t_pwm();
      plen();
      chk(n[15:0] + 16'h1, 16'(buck_ctrl_pkg::PERIOD_NORMAL));
      cyc(1);
      k = 0;
      repeat (8) begin
         if (high_gate_out === 1'b1) k++;
         cyc(1);
      end
      chk(k > 0 && k < 8, 16'h1);
      // The low side comes on after the gap and stands into the next start.
      cyc(1);
      chk(period_start_out, 16'h1);
      chk(low_gate_out, 16'h1);
   endtask
   task automatic t_oc();
      slow = 1'b1;
      wait_for(5, 20);
      overcurrent_trip_in = 1'b1;
      #1 chk(high_gate_out, 16'h0);
      cyc(1);
      overcurrent_trip_in = 1'b0;
      slow = 1'b0;
   endtask
   task automatic t_skip();
      light_load = 1'b1;
      repeat (10) plen();
      light_load = 1'b0;
      repeat (2) plen();
      light_load = 1'b1;
      for (k = 0; k < 30 && skip_mode_out !== 1'b1; k++) plen();
      chk(k >= 14 && k <= 19, 16'h1);
      wait_for(0, 400);
      wait_for(5, 4);
      cyc(6);
      chk(high_gate_out, 16'h0);
      out_above_upper_in = 1'b1;
      cyc(4);
      off_for(40);
      out_above_upper_in = 1'b0;
      out_below_nominal_in = 1'b1;
      wait_for(5, 30);
      out_below_nominal_in = 1'b0;
      out_below_lower_in = 1'b1;
      wait_for(6, 10);
      out_below_lower_in = 1'b0;
      light_load = 1'b0;
   endtask
   task automatic t_short();
      output_short_detect_in = 1'b1;
      plen();
      plen();
      chk(n[15:0] + 16'h1, 16'(buck_ctrl_pkg::PERIOD_FOLDBACK));
      output_short_detect_in = 1'b0;
   endtask
   task automatic t_dropout();
      dropout_in = 1'b1;
      wait_for(5, 20);
      k = 0;
      repeat (30) begin
         if (high_gate_out === 1'b1) k++;
         cyc(1);
      end
      chk(k[15:0], 16'h1e);
      dropout_in = 1'b0;
   endtask
   task automatic t_hold(input logic temp);
      over_temp_in = temp;
      supply_low_lockout_in = !temp;
      cyc(6);
      off_for(20);
      chk(soft_start_active_out, 16'h0);
      over_temp_in = 1'b0;
      supply_low_lockout_in = 1'b0;
      run_up();
   endtask
   initial begin
      reset_n_in = 1'b0;
      {enable_in, supply_low_lockout_in, over_temp_in, overcurrent_trip_in,
         output_short_detect_in, out_above_upper_in, out_below_nominal_in,
         out_below_lower_in, dropout_in, light_load, slow} = '0;
      cyc(12);
      chk({discharge_out, high_gate_out, low_gate_out, reference_wake_out,
         soft_start_active_out, skip_mode_out}, 16'h20);
      reset_n_in = 1'b1;
      t_startup();
      t_pwm();
      t_oc();
      t_skip();
      t_short();
      t_dropout();
      t_hold(1'b1);
      t_hold(1'b0);
      t_pwm();
      enable_in = 1'b0;
      cyc(5);
      chk(discharge_out, 16'h1);
      off_for(10);
      conclude();
   end
endmodule
bind buck_switch_control_logic buck_ctrl_chk
   #(.SOFT_START_CYCLES(SOFT_START_CYCLES)) u_chk (.clk_in, .reset_n_in,
   .enable_in, .supply_low_lockout_in, .over_temp_in, .loop_trip_in,
   .overcurrent_trip_in, .dropout_in, .high_gate_out, .low_gate_out,
   .reference_wake_out, .soft_start_active_out, .soft_start_ramp_out,
   .skip_mode_out, .period_start_out);
